// *** tofs_consts.svh ***
// Constants of the ranging sensor target port and measurement sequencer.
// Included by the design files; definitions only.
`ifndef TOFS_CONSTS_SVH
`define TOFS_CONSTS_SVH

// ==========================================================
// Bus addressing
`define TOFS_TGT_ADDR 7'h29
`define TOFS_PTR_LAST 8'h37
`define TOFS_REG_TOP 8'h54
`define TOFS_REG_RST_VAL 8'h00

// ==========================================================
// Register offsets and values with side effects
`define TOFS_REG_CMD 8'h00
`define TOFS_CMD_START 8'h80
`define TOFS_REG_FLAG 8'h01
`define TOFS_FLAG_DONE_BIT 1
`define TOFS_REG_CTRL 8'h02
`define TOFS_CTRL_INIT_BIT 0
`define TOFS_REG_STATUS 8'h2e
`define TOFS_FAULT_CLR_VAL 8'h00
`define TOFS_REG_ID 8'h41

// ==========================================================
// Result codes
`define TOFS_ERR_NONE 8'h00
`define TOFS_ERR_SHORT 8'h01
`define TOFS_ERR_WEAK 8'h02
`define TOFS_ERR_SNR 8'h04
`define TOFS_ERR_AMB 8'h08
`define TOFS_ERR_ALIAS 8'h10
`define TOFS_ERR_CALC 8'h20
`define TOFS_ERR_XTALK 8'h80

`endif

// *** tofs_pkg.sv ***
// Types shared by the ranging sensor target port and sequencer.
// No dependencies.
package tofs_pkg;

   // ==========================================================
   // Serial engine and measurement states
   typedef enum logic [1:0] {TS_IDLE, TS_ADDR, TS_WRITE, TS_READ} tofs_i2c_st_t;
   typedef enum logic [1:0] {TM_PDN, TM_MAIN, TM_ALIAS} tofs_meas_st_t;

   // ==========================================================
   // Flags reported by the optical front end during a shot
   typedef struct packed {
      logic short_det;
      logic weak_signal;
      logic poor_snr_fault;
      logic ambient_overload_fault;
      logic range_alias_fault;
      logic calc_fault;
      logic xtalk_fault;
   } tofs_afe_t;

endpackage

// *** tofs_sync.sv ***
// Two-flop synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module tofs_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // Pins idle high on an open-drain bus
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= '1;
         q <= '1;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // tofs_sync

// *** tofs_meas.sv ***
// Single-shot measurement sequencer with alias check shot.
// Assumes the front end pulses shot_done once per shot.
`timescale 1ns/1ps
module tofs_meas import tofs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic clr_fault,
   // Front end
   input tofs_afe_t afe,
   input wire logic shot_done,
   output logic emit_en,
   output logic alias_sel,
   // Status
   output logic busy,
   output logic done,
   output logic [7:0] code,
   output logic emitter_short_fault
);
   `include "tofs_consts.svh"
   tofs_meas_st_t st_reg;
   tofs_afe_t acc_reg;
   logic short_set;

   function automatic logic [7:0] encode(input tofs_afe_t f, input logic sh);
      if (sh) return `TOFS_ERR_SHORT;
      if (f.calc_fault) return `TOFS_ERR_CALC;
      if (f.range_alias_fault) return `TOFS_ERR_ALIAS;
      if (f.ambient_overload_fault) return `TOFS_ERR_AMB;
      if (f.poor_snr_fault) return `TOFS_ERR_SNR;
      if (f.weak_signal) return `TOFS_ERR_WEAK;
      if (f.xtalk_fault) return `TOFS_ERR_XTALK;
      return `TOFS_ERR_NONE;
   endfunction

   assign busy = (st_reg != TM_PDN);
   assign short_set = busy && afe.short_det;
   assign emit_en = busy && !emitter_short_fault;
   assign alias_sel = (st_reg == TM_ALIAS);

   // ==========================================================
   // One start, main shot, alias shot, back to power-down
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= TM_PDN;
      end else begin
         unique case (st_reg)
            TM_PDN: if (start) st_reg <= TM_MAIN;
            TM_MAIN: if (shot_done) st_reg <= TM_ALIAS;
            TM_ALIAS: if (shot_done) st_reg <= TM_PDN;
            default: st_reg <= TM_PDN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || (st_reg == TM_PDN && start)) acc_reg <= '0;
      else if (busy) acc_reg <= acc_reg | afe;
   end

   // Set wins over clear
   always_ff @(posedge clk) begin
      if (!rst_n) emitter_short_fault <= 1'b0;
      else if (short_set) emitter_short_fault <= 1'b1;
      else if (clr_fault) emitter_short_fault <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         code <= `TOFS_ERR_NONE;
         done <= 1'b0;
      end else begin
         done <= (st_reg == TM_ALIAS) && shot_done;
         if (st_reg == TM_ALIAS && shot_done)
            code <= encode(acc_reg | afe, emitter_short_fault | short_set);
      end
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_two_shots;
      (st_reg == TM_MAIN) ##0 shot_done ##1 (st_reg == TM_ALIAS);
   endsequence
   one_shot_a: assert property (s_two_shots ##[0:1000]
      (shot_done && st_reg == TM_ALIAS) |=> st_reg == TM_PDN
      ##1 (st_reg == TM_PDN || $past(start))) else $error("no return to power-down");
   short_off_a: assert property (short_set |=> emitter_short_fault && !emit_en)
      else $error("emitter on during short");
   code_zero_a: assert property (done && (code == `TOFS_ERR_NONE)
      |-> !$past(emitter_short_fault)) else $error("zero code with short");
endmodule // tofs_meas

// *** tofs_i2c_ctrl.sv ***
// Serial target port, register file and measurement control of a
// time-of-flight ranging sensor.
// Assumes scl and sda are open-drain pins from another clock domain,
// sampled here at 100 MHz; bus rate is far below the sample rate.
//
// Operation
// - Answer as bus target at seven-bit address 0x29 only.
// - Each written data byte advances the register pointer.
// - A stop condition ends a write; later bytes are not stored.
// - Auto-increment never passes from 0x37 to 0x38, reading or writing.
// - Host acknowledge on a read byte returns the next register next.
// - Host not-acknowledge ends the read; the pin is released.
// - Repeated start after the pointer byte switches to reading.
// - No clock stretching; general-call address is ignored.
// - Reset clears all registers and leaves the sequencer powered down.
// - Each start runs one measurement, then returns to power-down alone.
// - Result code zero means valid; nonzero means unreliable distance.
// - Codes: weak signal 0x02, poor SNR 0x04, ambient overload 0x08.
// - Codes: alias 0x10, calculation fault 0x20, panel crosstalk 0x80.
// - Shorted emitter reports 0x01 and switches the emitter drive off.
// - Short fault latches until 0x00 written at 2EH or reinitialisation.
// - An extra shot with changed period flags far-target aliasing.
`timescale 1ns/1ps
module tofs_i2c_ctrl import tofs_pkg::*; #(
   parameter int REGS = 85,
   parameter logic [7:0] DEV_ID = 8'h5a // Arbitrary identification value
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Optical front end
   input tofs_afe_t afe,
   input wire logic shot_done,
   output logic emit_en,
   output logic alias_sel,
   // Status
   output logic meas_busy,
   output logic [7:0] ranging_error_code,
   output logic emitter_short_fault
);
   `include "tofs_consts.svh"

   // ==========================================================
   // Pin sampling and bus conditions
   logic [1:0] pin_s;
   logic scl_s;
   logic sda_s;
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   tofs_sync #(.W(2)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({scl_i, sda_i}),
      .q(pin_s)
   );

   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise = scl_s && !scl_d_reg;
   assign scl_fall = !scl_s && scl_d_reg;
   assign start_ev = scl_s && scl_d_reg && !sda_s && sda_d_reg;
   assign stop_ev = scl_s && scl_d_reg && sda_s && !sda_d_reg;

   // ==========================================================
   // Byte engine
   tofs_i2c_st_t st_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic rw_reg;
   logic mack_reg;
   logic sda_low_reg;
   logic byte_end;
   logic ack_end;
   logic addr_hit;

   // Ninth falling edge closes the acknowledge slot
   assign byte_end = scl_fall && (bit_reg == 4'h8);
   assign ack_end = scl_fall && (bit_reg == 4'h9);
   // General call (all zeros) never matches
   assign addr_hit = (shift_reg[7:1] == `TOFS_TGT_ADDR);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= TS_IDLE;
      end else if (start_ev) begin
         st_reg <= TS_ADDR;
      end else if (stop_ev) begin
         st_reg <= TS_IDLE;
      end else if (byte_end && st_reg == TS_ADDR && !addr_hit) begin
         st_reg <= TS_IDLE;
      end else if (ack_end) begin
         unique case (st_reg)
            TS_ADDR: st_reg <= rw_reg ? TS_READ : TS_WRITE;
            TS_READ: if (!mack_reg) st_reg <= TS_IDLE;
            default: st_reg <= st_reg;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || start_ev || ack_end) begin
         bit_reg <= 4'h0;
      end else if (scl_rise && bit_reg != 4'h9) begin
         bit_reg <= bit_reg + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shift_reg <= 8'h00;
         mack_reg <= 1'b0;
      end else if (scl_rise) begin
         if (bit_reg < 4'h8) shift_reg <= {shift_reg[6:0], sda_s};
         if (bit_reg == 4'h8) mack_reg <= !sda_s;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) rw_reg <= 1'b0;
      else if (byte_end && st_reg == TS_ADDR) rw_reg <= shift_reg[0];
   end

   // ==========================================================
   // Register pointer
   logic [7:0] ptr_reg;
   logic first_reg;
   logic blocked_reg;
   logic data_byte;
   logic wr_ev;
   logic rd_next;
   logic rd_first;
   logic advance;

   assign data_byte = byte_end && st_reg == TS_WRITE;
   assign wr_ev = data_byte && !first_reg && !blocked_reg;
   assign rd_first = ack_end && st_reg == TS_ADDR && rw_reg;
   assign rd_next = ack_end && st_reg == TS_READ && mack_reg;
   assign advance = wr_ev || (rd_next && !blocked_reg);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         first_reg <= 1'b0;
      end else if (start_ev) begin
         first_reg <= 1'b1;
      end else if (data_byte || rd_first) begin
         first_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr_reg <= 8'h00;
         blocked_reg <= 1'b0;
      end else if (data_byte && first_reg) begin
         ptr_reg <= shift_reg;
         blocked_reg <= 1'b0;
      end else if (advance) begin
         if (ptr_reg == `TOFS_PTR_LAST) blocked_reg <= 1'b1;
         else ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // ==========================================================
   // Register file and side effects
   logic [7:0] regs_reg [REGS];
   logic init_ev;
   logic start_cmd_reg;
   logic clr_req;
   logic done_flag_reg;
   logic meas_done;
   logic [7:0] rd_ptr;
   logic [7:0] rd_data;

   // A write of the init bit reloads the register file defaults; the status code and completion flag keep their values
   assign init_ev = wr_ev && ptr_reg == `TOFS_REG_CTRL
      && shift_reg[`TOFS_CTRL_INIT_BIT];
   assign clr_req = init_ev || (wr_ev && ptr_reg == `TOFS_REG_STATUS
      && shift_reg == `TOFS_FAULT_CLR_VAL);

   always_ff @(posedge clk) begin
      if (!rst_n || init_ev) begin
         for (int i = 0; i < REGS; i++) regs_reg[i] <= `TOFS_REG_RST_VAL;
      end else if (wr_ev && ptr_reg <= `TOFS_REG_TOP) begin
         regs_reg[ptr_reg[6:0]] <= shift_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) start_cmd_reg <= 1'b0;
      else start_cmd_reg <= wr_ev && ptr_reg == `TOFS_REG_CMD
         && shift_reg == `TOFS_CMD_START;
   end

   // Completion is sticky; a new completion beats a read clearing it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         done_flag_reg <= 1'b0;
      end else if (meas_done) begin
         done_flag_reg <= 1'b1;
      end else if ((rd_first || rd_next) && rd_ptr == `TOFS_REG_FLAG) begin
         done_flag_reg <= 1'b0;
      end
   end

   function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic blk);
      logic [7:0] v;
      v = 8'h00;
      if (blk) v = 8'h00;
      else if (p == `TOFS_REG_STATUS) v = ranging_error_code;
      else if (p == `TOFS_REG_ID) v = DEV_ID;
      else if (p == `TOFS_REG_FLAG) v[`TOFS_FLAG_DONE_BIT] = done_flag_reg;
      else if (p <= `TOFS_REG_TOP) v = regs_reg[p[6:0]];
      return v;
   endfunction

   // Pointer as it stands after this acknowledge slot
   assign rd_ptr = (rd_next && !blocked_reg && ptr_reg != `TOFS_PTR_LAST)
      ? ptr_reg + 8'h01 : ptr_reg;
   assign rd_data = rd_byte(rd_ptr, blocked_reg
      || (rd_next && ptr_reg == `TOFS_PTR_LAST));

   // ==========================================================
   // Data pin drive, changed only while scl is low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_reg <= 8'h00;
      end else if (rd_first || rd_next) begin
         tx_reg <= rd_data;
      end else if (scl_fall && st_reg == TS_READ && bit_reg < 4'h8) begin
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n || start_ev || stop_ev) begin
         sda_low_reg <= 1'b0;
      end else if (byte_end) begin
         unique case (st_reg)
            TS_ADDR: sda_low_reg <= addr_hit;
            TS_WRITE: sda_low_reg <= 1'b1;
            default: sda_low_reg <= 1'b0;
         endcase
      end else if (rd_first || rd_next) begin
         sda_low_reg <= !rd_data[7];
      end else if (ack_end) begin
         sda_low_reg <= 1'b0;
      end else if (scl_fall && st_reg == TS_READ && bit_reg != 4'h0
                   && bit_reg < 4'h8) begin
         sda_low_reg <= !tx_reg[6];
      end
   end

   // Open drain only; scl is never driven, so no stretching
   assign sda_o = 1'b0;
   assign sda_oe_n = !sda_low_reg;

   // ==========================================================
   // Measurement sequencer
   tofs_meas u_meas (
      .clk(clk),
      .rst_n(rst_n),
      .start(start_cmd_reg),
      .clr_fault(clr_req),
      .afe(afe),
      .shot_done(shot_done),
      .emit_en(emit_en),
      .alias_sel(alias_sel),
      .busy(meas_busy),
      .done(meas_done),
      .code(ranging_error_code),
      .emitter_short_fault(emitter_short_fault)
   );

   // ==========================================================
   // Checks
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_addr_byte;
      byte_end && st_reg == TS_ADDR;
   endsequence

   sequence s_read_nack;
      scl_rise && st_reg == TS_READ && bit_reg == 4'h8 && sda_s ##1 !scl_rise [*1];
   endsequence

   addr_ack_a: assert property (s_addr_byte ##0 addr_hit |=> !sda_oe_n)
      else $error("own address not acknowledged");
   no_gcall_a: assert property (s_addr_byte ##0 (shift_reg[7:1] == 7'h00)
      |=> sda_oe_n && st_reg == TS_IDLE)
      else $error("general call answered");
   stop_end_a: assert property (stop_ev |=> st_reg == TS_IDLE && sda_oe_n
      ##1 !(wr_ev && !start_ev))
      else $error("stop did not end transfer");
   ptr_step_a: assert property (wr_ev && ptr_reg != `TOFS_PTR_LAST
      |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("pointer did not advance");
   no_carry_a: assert property (advance && ptr_reg == `TOFS_PTR_LAST
      |=> blocked_reg && ptr_reg == `TOFS_PTR_LAST)
      else $error("pointer crossed boundary");
   // Only the slot of the refused byte; a later frame would restart the engine
   nack_rel_a: assert property (s_read_nack ##[0:30] (ack_end && st_reg == TS_READ)
      |=> st_reg == TS_IDLE && sda_oe_n)
      else $error("data held after not-acknowledge");
   rstart_a: assert property (start_ev |=> st_reg == TS_ADDR && bit_reg == 4'h0)
      else $error("repeated start not taken");
   first_ptr_a: assert property (data_byte && first_reg
      |=> ptr_reg == $past(shift_reg) && !first_reg)
      else $error("pointer byte not loaded");
   fault_clr_a: assert property (clr_req && !afe.short_det
      |=> ##1 !emitter_short_fault)
      else $error("short fault not cleared");
   meas_start_a: assert property (start_cmd_reg && !meas_busy |=> meas_busy)
      else $error("start ignored");
endmodule // tofs_i2c_ctrl

// *** tofs_host_model.sv ***
// Bus controller model that drives the sensor's serial pins.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module tofs_host_model (
   // Serial pins
   output logic scl,
   output logic sda_pull,
   input wire logic sda_in
);
   // Set by the bench to hold the clock low longer
   logic slow = 1'b0;

   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // ==========================================================
   // Bit level: clock stands high between frames
   task automatic bit_io(input logic b, output logic r);
      #31.25 sda_pull = ~b;
      if (slow) #400;
      #31.25 scl = 1'b1;
      #31.25 r = sda_in;
      #31.25 scl = 1'b0;
   endtask

   // Also serves as repeated start from a low clock
   task automatic start();
      #31.25 sda_pull = 1'b0;
      #31.25 scl = 1'b1;
      #31.25 sda_pull = 1'b1;
      #31.25 scl = 1'b0;
   endtask

   task automatic stop();
      #31.25 sda_pull = 1'b1;
      #31.25 scl = 1'b1;
      #31.25 sda_pull = 1'b0;
      #31.25;
   endtask

   // ==========================================================
   // Byte level: send 8'hff to read; host_ack low ends a read
   task automatic xfer(input logic [7:0] d, input logic host_ack, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(~host_ack, ack);
      ack = ~ack;
   endtask
endmodule // tofs_host_model

// *** testbench.sv ***
// Self-checking bench of the ranging sensor target port and sequencer.
// Assumes tofs_host_model drives the bus; front-end flags come from here.
`timescale 1ns/1ps
`include "tofs_consts.svh"
module testbench import tofs_pkg::*;;
   // ==========================================================
   // Clock, pins, bookkeeping
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic shot_done = 1'b0;
   tofs_afe_t afe = '0;
   logic scl, sda_pull, sda_o, sda_oe_n, sda_w;
   logic emit_en, alias_sel, meas_busy, emitter_short_fault;
   logic [7:0] ranging_error_code;
   int errors = 0;
   int n_tests = 0;
   int seed = 36;
   logic fault_exp = 1'b0;
   logic [7:0] rd [8];
   logic [7:0] wd [8];

   always #5 clk = ~clk;
   // Open-drain wire with pull-up
   assign sda_w = ~sda_pull & (sda_oe_n | sda_o);

   tofs_host_model tofs_host_model_i (.scl(scl), .sda_pull(sda_pull), .sda_in(sda_w));
   tofs_i2c_ctrl tofs_i2c_ctrl_i (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .afe(afe), .shot_done(shot_done),
      .emit_en(emit_en), .alias_sel(alias_sel), .meas_busy(meas_busy),
      .ranging_error_code(ranging_error_code), .emitter_short_fault(emitter_short_fault));

   // ==========================================================
   // Checking and closing
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wait_busy(input logic want);
      int k;
      k = 0;
      while (meas_busy !== want && k < 200) begin
         @(posedge clk);
         #1 k++;
      end
      if (k == 200) begin
         errors++;
         $display("unexpected at %0t: busy wait ran out", $time);
         conclude();
      end
   endtask

   // ==========================================================
   // Bus transactions
   task automatic reg_wr(input logic [7:0] ptr, input int n);
      logic [7:0] q;
      logic a;
      tofs_host_model_i.start();
      tofs_host_model_i.xfer({`TOFS_TGT_ADDR, 1'b0}, 1'b0, q, a);
      chk(8'(a), 8'h01, "write address ack");
      tofs_host_model_i.xfer(ptr, 1'b0, q, a);
      for (int i = 0; i < n; i++) tofs_host_model_i.xfer(wd[i], 1'b0, q, a);
      tofs_host_model_i.stop();
   endtask

   task automatic reg_rd(input logic [7:0] ptr, input int n);
      logic [7:0] q;
      logic a;
      tofs_host_model_i.start();
      tofs_host_model_i.xfer(8'h52, 1'b0, q, a);
      tofs_host_model_i.xfer(ptr, 1'b0, q, a);
      tofs_host_model_i.start();
      tofs_host_model_i.xfer(8'h53, 1'b0, q, a);
      chk(8'(a), 8'h01, "read address ack");
      for (int i = 0; i < n; i++) tofs_host_model_i.xfer(8'hff, i < n - 1, rd[i], a);
      #45 chk(8'(sda_oe_n), 8'h01, "pin released after nack");
      tofs_host_model_i.stop();
   endtask

   // ==========================================================
   // Measurement
   function automatic logic [7:0] exp_code(input tofs_afe_t f, input logic flt);
      if (flt || f.short_det) return 8'h01;
      if (f.calc_fault) return 8'h20;
      if (f.range_alias_fault) return 8'h10;
      if (f.ambient_overload_fault) return 8'h08;
      if (f.poor_snr_fault) return 8'h04;
      if (f.weak_signal) return 8'h02;
      if (f.xtalk_fault) return 8'h80;
      return 8'h00;
   endfunction

   task automatic meas(input tofs_afe_t f);
      logic [7:0] want;
      want = exp_code(f, fault_exp);
      wd[0] = 8'h80;
      reg_wr(8'h00, 1);
      wait_busy(1'b1);
      chk(8'(emit_en), 8'(!fault_exp), "emitter at start");
      @(posedge clk);
      afe <= f;
      repeat (4) @(posedge clk);
      shot_done <= 1'b1;
      @(posedge clk);
      shot_done <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(8'(alias_sel & meas_busy), 8'h01, "alias shot");
      fault_exp = fault_exp | f.short_det;
      chk(8'(emit_en), 8'(!fault_exp), "emitter drive");
      @(posedge clk);
      shot_done <= 1'b1;
      @(posedge clk);
      shot_done <= 1'b0;
      afe <= '0;
      @(posedge clk);
      #1 chk(8'(meas_busy), 8'h00, "back to power-down");
      chk(ranging_error_code, want, "result code");
      chk(8'(emitter_short_fault), 8'(fault_exp), "short latch");
      repeat (30) @(posedge clk);
      #1 chk(8'(meas_busy), 8'h00, "one shot per start");
      reg_rd(`TOFS_REG_STATUS, 1);
      chk(rd[0], want, "status register");
      reg_rd(`TOFS_REG_FLAG, 1);
      chk(8'(rd[0][1]), 8'h01, "completion flag");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] base;
      logic [7:0] q;
      logic a;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(8'({sda_oe_n, meas_busy, emit_en, emitter_short_fault}), 8'h08, "after reset");
      chk(ranging_error_code, 8'h00, "code after reset");
      reg_rd(8'h03, 4);
      for (int i = 0; i < 4; i++) chk(rd[i], 8'h00, "register default");
      // Foreign address, then general call
      for (int i = 0; i < 2; i++) begin
         tofs_host_model_i.start();
         tofs_host_model_i.xfer(i ? 8'h00 : 8'h50, 1'b0, q, a);
         chk(8'(a), 8'h00, "no ack to other address");
         tofs_host_model_i.stop();
      end
      // Burst across 0x37, with the clock held low longer
      for (int i = 0; i < 6; i++) wd[i] = 8'($random(seed));
      tofs_host_model_i.slow = 1'b1;
      reg_wr(8'h34, 6);
      tofs_host_model_i.slow = 1'b0;
      reg_rd(8'h34, 6);
      for (int i = 0; i < 6; i++) chk(rd[i], i < 4 ? wd[i] : 8'h00, "burst at 0x37");
      reg_rd(8'h38, 1);
      chk(rd[0], 8'h00, "0x38 not reached");
      // Configuration load; a lone pointer byte after stop must store nothing
      base = {3'b000, 5'($random(seed))} + 8'h03;
      for (int i = 0; i < 3; i++) wd[i] = 8'($random(seed));
      reg_wr(base, 3);
      reg_wr(base + 8'h01, 0);
      reg_rd(base, 4);
      for (int i = 0; i < 4; i++) chk(rd[i], i < 3 ? wd[i] : 8'h00, "config burst");
      // Every single code except short, clean result, random mixes
      for (int i = 0; i < 7; i++) meas(i == 6 ? '0 : tofs_afe_t'(7'h01 << i));
      for (int i = 0; i < 3; i++) meas(tofs_afe_t'(7'($random(seed)) & 7'h3f));
      // Short fault, cleared by status write
      meas(tofs_afe_t'(7'h40 | 7'($random(seed))));
      meas('0);
      wd[0] = 8'h00;
      reg_wr(`TOFS_REG_STATUS, 1);
      fault_exp = 1'b0;
      chk(8'(emitter_short_fault), 8'h00, "cleared by status write");
      meas('0);
      // Short fault, cleared by reinitialisation
      meas(tofs_afe_t'(7'h40));
      wd[0] = 8'h01;
      reg_wr(`TOFS_REG_CTRL, 1);
      fault_exp = 1'b0;
      chk(8'(emitter_short_fault), 8'h00, "cleared by reinit");
      reg_rd(base, 1);
      chk(rd[0], 8'h00, "registers reinitialised");
      conclude();
   end
endmodule // testbench
